/* File: src/pirqw_params.svh */
// constants for the peripheral interrupt enable and low-power wake block
`ifndef PIRQW_PARAMS_SVH
`define PIRQW_PARAMS_SVH
// apb byte offsets
`define PIRQW_OFF_ENABLE2  8'h00
`define PIRQW_OFF_INTCTL   8'h04
`define PIRQW_OFF_POWER    8'h08
`define PIRQW_OFF_PINCFG   8'h0C
`define PIRQW_OFF_FLAGS    8'h10
// interrupt control bits
`define PIRQW_BIT_GLOBAL   7
`define PIRQW_BIT_GATE     6
`define PIRQW_BIT_PCGRP    3
// power control bit
`define PIRQW_BIT_WAKE_EN  1
// pin config bits
`define PIRQW_BIT_LATCH    0
`define PIRQW_BIT_DIR_IN   1
`define PIRQW_BIT_IOC_EN   2
`define PIRQW_BIT_LEVEL    3
// flags bits, pin change flag below the peripheral nibble
`define PIRQW_BIT_PCFLAG   0
// peripheral enable / flag nibble position
`define PIRQW_NIB_LSB      4
// reset values
`define PIRQW_RST_NIB      4'h0
`define PIRQW_RST_DIR_IN   1'b1
// interrupt vector address
`define PIRQW_VECTOR       16'h0004
`endif

/* File: src/pirqw_pkg.sv */
// types shared by the peripheral interrupt enable and wake block
package pirqw_pkg;
	// peripheral events, ordered as enable bits 7..4
	typedef struct packed {
		logic osc_fail;
		logic cmp2;
		logic cmp1;
		logic ee_done;
	} pirqw_evt_s;

	typedef enum logic [0:0] {
		PIRQW_RUN   = 1'b0,
		PIRQW_SLEEP = 1'b1
	} pirqw_fsm_e;

	typedef struct packed {
		logic [3:0]  en2;
		logic        glob;
		logic        gate;
		logic        pcgrp;
		logic        wake_en;
		logic        pin_lat;
		logic        pin_dir_in;
		logic        ioc_en;
		logic [3:0]  flags;
		logic        pc_flag;
		logic        pin_prev;
		pirqw_fsm_e  fsm;
		logic        wake;
		logic        vec;
	} pirqw_st_s;
endpackage

/* File: src/pirqw_top.sv */
// peripheral interrupt enable register 2 and low-power wake on pin 0
//
// Function
// - no peripheral interrupt leaves unless the peripheral gate bit is set
// - enable bit 7 passes the oscillator fail interrupt
// - enable bit 6 passes the comparator 2 interrupt
// - enable bit 4 passes the eeprom write complete interrupt
// - wake enable bit turns on the pin 0 current sink
// - slow fall on pin 0 gives one pin change event
// - pin 0 low while sleeping wakes the core; o_irq rises only with global enable set
// - after wake with global enable set, branch to vector 0004h
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "pirqw_params.svh"

module pirqw_top (
	// clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// apb slave
	input  wire logic                   i_psel,
	input  wire logic                   i_penable,
	input  wire logic                   i_pwrite,
	input  wire logic [7:0]             i_paddr,
	input  wire logic [31:0]            i_pwdata,
	output logic                        o_pready,
	output logic                        o_pslverr,
	output logic [31:0]                 o_prdata,
	// peripheral event pulses
	input  wire pirqw_pkg::pirqw_evt_s  i_evt,
	// core sleep handshake
	input  wire logic                   i_sleep_req,
	output logic                        o_irq,
	output logic                        o_sleeping,
	output logic                        o_wake,
	output logic                        o_vector_take,
	output logic [15:0]                 o_vector_addr,
	// pin 0
	input  wire logic                   i_pin0,
	output logic                        o_pin0_o,
	output logic                        o_pin0_oe,
	output logic                        o_sink_en
);
	import pirqw_pkg::*;

	pirqw_st_s   st_q;
	pirqw_st_s   st_d;
	logic        acc;
	logic        wr;
	logic        mapped;
	logic        pc_evt;
	logic        per_pend;
	logic        pc_pend;
	logic        wake_cond;
	logic [31:0] rd;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus decode, zero wait states
	assign acc    = i_psel & i_penable;
	assign wr     = acc & i_pwrite;
	assign mapped = hit(i_paddr, `PIRQW_OFF_ENABLE2)
		| hit(i_paddr, `PIRQW_OFF_INTCTL)
		| hit(i_paddr, `PIRQW_OFF_POWER)
		| hit(i_paddr, `PIRQW_OFF_PINCFG)
		| hit(i_paddr, `PIRQW_OFF_FLAGS);
	assign o_pready  = 1'b1;
	assign o_pslverr = acc & ~mapped;

	always_comb begin
		rd = 32'h0000_0000;
		if (hit(i_paddr, `PIRQW_OFF_ENABLE2)) begin
			// low nibble stays zero: unimplemented
			rd[`PIRQW_NIB_LSB +: 4] = st_q.en2;
		end
		if (hit(i_paddr, `PIRQW_OFF_INTCTL)) begin
			rd[`PIRQW_BIT_GLOBAL] = st_q.glob;
			rd[`PIRQW_BIT_GATE]   = st_q.gate;
			rd[`PIRQW_BIT_PCGRP]  = st_q.pcgrp;
		end
		if (hit(i_paddr, `PIRQW_OFF_POWER)) begin
			rd[`PIRQW_BIT_WAKE_EN] = st_q.wake_en;
		end
		if (hit(i_paddr, `PIRQW_OFF_PINCFG)) begin
			rd[`PIRQW_BIT_LATCH]  = st_q.pin_lat;
			rd[`PIRQW_BIT_DIR_IN] = st_q.pin_dir_in;
			rd[`PIRQW_BIT_IOC_EN] = st_q.ioc_en;
			rd[`PIRQW_BIT_LEVEL]  = st_q.pin_prev;
		end
		if (hit(i_paddr, `PIRQW_OFF_FLAGS)) begin
			rd[`PIRQW_NIB_LSB +: 4] = st_q.flags;
			rd[`PIRQW_BIT_PCFLAG]   = st_q.pc_flag;
		end
	end
	// read data is a mux of flip-flops only
	assign o_prdata = (acc & ~i_pwrite) ? rd : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// interrupt gating
	// the pin compares against its last sampled level, so a slow ramp
	// that crosses the low threshold once gives a single event
	assign pc_evt = st_q.ioc_en & st_q.pin_dir_in
		& (i_pin0 != st_q.pin_prev);
	assign per_pend  = st_q.gate & |(st_q.flags & st_q.en2);
	assign pc_pend   = st_q.pcgrp & st_q.pc_flag;
	// wake does not need the global enable; o_irq and the branch do
	assign wake_cond = per_pend | pc_pend;
	assign o_irq     = st_q.glob & wake_cond;

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_d      = st_q;
		st_d.wake = 1'b0;
		st_d.vec  = 1'b0;
		st_d.pin_prev = i_pin0;
		if (wr && hit(i_paddr, `PIRQW_OFF_ENABLE2)) begin
			st_d.en2 = i_pwdata[`PIRQW_NIB_LSB +: 4];
		end
		if (wr && hit(i_paddr, `PIRQW_OFF_INTCTL)) begin
			st_d.glob  = i_pwdata[`PIRQW_BIT_GLOBAL];
			st_d.gate  = i_pwdata[`PIRQW_BIT_GATE];
			st_d.pcgrp = i_pwdata[`PIRQW_BIT_PCGRP];
		end
		if (wr && hit(i_paddr, `PIRQW_OFF_POWER)) begin
			st_d.wake_en = i_pwdata[`PIRQW_BIT_WAKE_EN];
		end
		if (wr && hit(i_paddr, `PIRQW_OFF_PINCFG)) begin
			st_d.pin_lat    = i_pwdata[`PIRQW_BIT_LATCH];
			st_d.pin_dir_in = i_pwdata[`PIRQW_BIT_DIR_IN];
			st_d.ioc_en     = i_pwdata[`PIRQW_BIT_IOC_EN];
		end
		// write one to clear; a new event in the same cycle wins
		if (wr && hit(i_paddr, `PIRQW_OFF_FLAGS)) begin
			st_d.flags   = st_q.flags & ~i_pwdata[`PIRQW_NIB_LSB +: 4];
			st_d.pc_flag = st_q.pc_flag & ~i_pwdata[`PIRQW_BIT_PCFLAG];
		end
		st_d.flags   = st_d.flags | i_evt;
		st_d.pc_flag = st_d.pc_flag | pc_evt;
		unique case (st_q.fsm)
			PIRQW_RUN: begin
				if (i_sleep_req) begin
					st_d.fsm = PIRQW_SLEEP;
				end
			end
			PIRQW_SLEEP: begin
				if (wake_cond) begin
					st_d.fsm  = PIRQW_RUN;
					st_d.wake = 1'b1;
					st_d.vec  = st_q.glob;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q            <= '0;
			st_q.en2        <= `PIRQW_RST_NIB;
			st_q.flags      <= `PIRQW_RST_NIB;
			st_q.pin_dir_in <= `PIRQW_RST_DIR_IN;
			st_q.fsm        <= PIRQW_RUN;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_sleeping    = st_q.fsm == PIRQW_SLEEP;
	assign o_wake        = st_q.wake;
	assign o_vector_take = st_q.vec;
	// driven always so the bus never floats between branches
	assign o_vector_addr = `PIRQW_VECTOR;
	assign o_sink_en     = st_q.wake_en;
	// charging the capacitor is plain output drive of the latch
	assign o_pin0_o  = st_q.pin_lat;
	assign o_pin0_oe = ~st_q.pin_dir_in;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	AST_GATE_BLOCKS: assert property (
		(!st_q.gate && !pc_pend) |-> !o_irq)
		else $error("peripheral interrupt passed with gate clear");
	AST_OSC_EN: assert property (
		(st_q.glob && st_q.gate && st_q.en2[3] && st_q.flags[3]) |-> o_irq)
		else $error("oscillator fail interrupt not raised");
	AST_CMP2_EN: assert property (
		(st_q.gate && !st_q.en2[2] && st_q.flags == 4'h4 && !pc_pend)
		|-> !o_irq)
		else $error("comparator 2 interrupt leaked while disabled");
	AST_CMP1_EN: assert property (
		(st_q.glob && st_q.gate && i_evt.cmp1 && st_q.en2[1]
		&& !(wr && hit(i_paddr, `PIRQW_OFF_ENABLE2))
		&& !(wr && hit(i_paddr, `PIRQW_OFF_INTCTL))) |=> o_irq)
		else $error("comparator 1 event did not raise interrupt");
	AST_EE_EN: assert property (
		(st_q.glob && st_q.gate && st_q.en2[0] && st_q.flags[0]) |-> o_irq)
		else $error("eeprom write interrupt not raised");
	AST_LOW_NIBBLE: assert property (
		(acc && !i_pwrite && hit(i_paddr, `PIRQW_OFF_ENABLE2))
		|-> o_prdata[3:0] == 4'h0)
		else $error("unimplemented enable bits read nonzero");
	AST_SINK_ON: assert property (
		(wr && hit(i_paddr, `PIRQW_OFF_POWER)
		&& i_pwdata[`PIRQW_BIT_WAKE_EN]) |=> o_sink_en)
		else $error("current sink not enabled by wake enable");
	AST_PIN_FALL: assert property (
		(st_q.ioc_en && st_q.pin_dir_in && st_q.pin_prev && !i_pin0)
		|=> st_q.pc_flag)
		else $error("falling pin 0 missed its change event");
	AST_WAKE: assert property (
		(o_sleeping && pc_pend) |=> (o_wake && !o_sleeping) ##1 !o_wake)
		else $error("pin change did not wake for exactly one cycle");
	AST_VECTOR: assert property (
		(o_sleeping && wake_cond) |=> (o_vector_take == $past(st_q.glob))
		&& o_vector_addr == `PIRQW_VECTOR)
		else $error("vector branch does not follow global enable");
endmodule

/* File: verif/pirqw_cap_model.sv */
// model of the external capacitor on the wake-up pin
`timescale 1ns/100ps

module pirqw_cap_model #(
	parameter int DISCH = 40
) (
	input  wire logic i_clk,
	input  wire logic i_oe,
	input  wire logic i_drv,
	input  wire logic i_sink_en,
	output logic      o_level
);
	int charge = 0;

	// the cap holds its charge unless the pin drives it or the sink pulls it down
	always @(posedge i_clk) begin
		if (i_oe)
			charge <= i_drv ? DISCH : 0;
		else if (i_sink_en && charge > 0)
			charge <= charge - 1;
	end

	// level falls below threshold only once fully drained
	assign o_level = i_oe ? i_drv : (charge > 0);
endmodule

/* File: verif/pirqw_top_test.sv */
// self-checking bench for the peripheral irq enable and wake block
`timescale 1ns/100ps
`include "pirqw_params.svh"

module pirqw_top_test;
	import pirqw_pkg::*;
	logic        clk = 0, rst = 1, sleep_req = 0;
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready, pslverr, err;
	pirqw_evt_s  evt = '0;
	logic        irq, sleeping, wake, vtake;
	logic [15:0] vaddr;
	logic        pin0, pin_o, pin_oe, sink_en;
	int          failures = 0;
	int          tests_run = 0;

	always #20 clk = ~clk;

	pirqw_top u_pirqw_top (
		.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
		.i_evt(evt), .i_sleep_req(sleep_req), .o_irq(irq),
		.o_sleeping(sleeping), .o_wake(wake), .o_vector_take(vtake),
		.o_vector_addr(vaddr), .i_pin0(pin0), .o_pin0_o(pin_o),
		.o_pin0_oe(pin_oe), .o_sink_en(sink_en));

	pirqw_cap_model #(.DISCH(40)) u_pirqw_cap_model (
		.i_clk(clk), .i_oe(pin_oe), .i_drv(pin_o),
		.i_sink_en(sink_en), .o_level(pin0));

	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one edge first so a released strobe is never raised in the same step
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(0, a, 32'h0000_0000, r);
		chk(r, exp);
	endtask

	task automatic pulse(input logic [3:0] m);
		evt <= pirqw_evt_s'(m);
		@(posedge clk);
		evt <= '0;
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic reg_run;
		chk({pin_oe, irq, sink_en, sleeping}, 4'h0);
		chk(vaddr, 16'h0004);
		rd(`PIRQW_OFF_ENABLE2, 32'h0000_0000);
		wr(`PIRQW_OFF_ENABLE2, 32'hFFFF_FFFF);
		rd(`PIRQW_OFF_ENABLE2, 32'h0000_00F0);
		rd(8'h14, 32'h0000_0000);
		chk(err, 1);
		$display("test reg_run done");
	endtask

	task automatic evt_run;
		int i;
		wr(`PIRQW_OFF_INTCTL, 32'h0000_00C0);
		for (i = 0; i < 4; i++) begin
			wr(`PIRQW_OFF_ENABLE2, 32'h0000_0010 << i);
			pulse(4'(1 << i));
			chk(irq, 1);
			wr(`PIRQW_OFF_FLAGS, 32'h0000_00F0);
			pulse(4'(1 << ((i + 1) % 4)));
			chk(irq, 0);
			wr(`PIRQW_OFF_FLAGS, 32'h0000_00F0);
		end
		wr(`PIRQW_OFF_ENABLE2, 32'h0000_00F0);
		wr(`PIRQW_OFF_INTCTL, 32'h0000_0080);
		pulse(4'hF);
		chk(irq, 0);
		wr(`PIRQW_OFF_INTCTL, 32'h0000_00C0);
		@(posedge clk);
		chk(irq, 1);
		wr(`PIRQW_OFF_FLAGS, 32'h0000_00F0);
		wr(`PIRQW_OFF_INTCTL, 32'h0000_0000);
		$display("test evt_run done");
	endtask

	// enables left set by evt_run must clear on a reset in mid-run
	task automatic reset_run;
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		rd(`PIRQW_OFF_ENABLE2, 32'h0000_0000);
		$display("test reset_run done");
	endtask

	// software order: charge, input, change irq, wake enable, sleep
	task automatic wake_run(input logic g);
		int n;
		wr(`PIRQW_OFF_PINCFG, 32'h0000_0001);
		repeat (3) @(posedge clk);
		chk({pin_oe, pin_o}, 2'b11);
		wr(`PIRQW_OFF_PINCFG, 32'h0000_0007);
		wr(`PIRQW_OFF_INTCTL, {24'h00_0000, g, 7'h08});
		wr(`PIRQW_OFF_FLAGS, 32'h0000_00F1);
		wr(`PIRQW_OFF_POWER, 32'h0000_0002);
		rd(`PIRQW_OFF_POWER, 32'h0000_0002);
		@(posedge clk);
		sleep_req <= 1;
		@(posedge clk);
		sleep_req <= 0;
		chk(sink_en, 1);
		@(posedge clk);
		chk(sleeping, 1);
		for (n = 0; n < 200 && wake !== 1'b1; n++) @(posedge clk);
		chk(wake, 1);
		chk({sleeping, vtake, irq}, {1'b0, g, g});
		rd(`PIRQW_OFF_FLAGS, 32'h0000_0001);
		rd(`PIRQW_OFF_PINCFG, 32'h0000_0007);
		wr(`PIRQW_OFF_POWER, 32'h0000_0000);
		@(posedge clk);
		chk(sink_en, 0);
		$display("test wake_run global %0d done", g);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		reg_run();
		evt_run();
		reset_run();
		wake_run(1'b1);
		wake_run(1'b0);
		close_out();
	end

	// whole run needs well under a thousand cycles
	initial begin
		#200000;
		failures++;
		close_out();
	end
endmodule
